// ==== hdl/ums_uart.v ====
// UART modem control, line status and modem status logic behind an APB register slave
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`include "ums_uart_consts.vh"
module ums_uart #(
  parameter DEPTH     = 16,
  parameter AW        = 4,
  parameter BAUD_DIV  = `UMS_BAUD_DIV,
  parameter AUTO_FLOW_ENABLE_MODE = 1,
  parameter PROG_TX_HOLD_EMPTY = 1
) (
  input  wire        sys_clk,
  input  wire        nrst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  input  wire        sin,
  input  wire        cts_n,
  input  wire        dsr_n,
  input  wire        dcd_n,
  input  wire        ri_n,
  output reg         sout,
  output reg         rts_n,
  output reg         dtr_n,
  output reg         user_output_a_pin,
  output reg         user_output_b_pin,
  output reg         intr
);
  localparam [5:0] RX_IDLE = 6'h01, RX_START = 6'h02, RX_DATA = 6'h04;
  localparam [5:0] RX_PAR = 6'h08, RX_STOP = 6'h10, RX_BRK = 6'h20;
  localparam [15:0] DIV = BAUD_DIV;
  localparam [AW:0] FULL = DEPTH;

  // Trigger level of a 2-bit code, receive or transmit table
  function [AW:0] ums_lvl;
    input [1:0] c;
    input       tx;
    begin
      case (c)
        2'h0:    ums_lvl = tx ? {(AW+1){1'b0}} : {{AW{1'b0}}, 1'b1};
        2'h1:    ums_lvl = tx ? {{(AW-1){1'b0}}, 2'b10} : FULL >> 2;
        2'h2:    ums_lvl = tx ? FULL >> 2 : FULL >> 1;
        default: ums_lvl = tx ? FULL >> 1 : FULL - {{(AW-1){1'b0}}, 2'b10};
      endcase
    end
  endfunction

  reg  [7:0]      int_enable_reg;
  reg             fcr_en;
  reg  [1:0]      rx_trig;
  reg  [1:0]      tx_trig;
  reg  [6:0]      lcr;
  reg  [5:0]      modem_control;
  reg  [10:0]     rmem [0:DEPTH-1];
  reg  [7:0]      tmem [0:DEPTH-1];
  reg  [AW-1:0]   rwp, rrp, twp, trp;
  reg  [AW:0]     rcount, tcount, err_cnt;
  reg             top_shown, rx_fifo_error_summary, lsr_bi, lsr_fe, lsr_pe, lsr_oe;
  reg             tx_hold_empty, tx_all_empty;
  reg  [3:0]      msr_prev, msr_delta;
  reg  [5:0]      rx_st;
  reg  [15:0]     rx_cnt, tx_cnt;
  reg  [2:0]      rx_bit;
  reg  [7:0]      rx_sh;
  reg             rx_p, rx_push, brk_done;
  reg  [10:0]     rx_word;
  reg  [19:0]     lo_cnt;
  reg  [11:0]     tx_sh;
  reg  [3:0]      tx_left;
  reg             tx_busy;
  reg  [31:0]     next_prdata;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode and shared terms
  wire        acc     = psel & penable;
  wire        wr      = acc & pwrite;
  wire        rd      = acc & ~pwrite;
  wire        rd_lsr  = rd & (paddr == `UMS_OFS_LSR);
  wire        rd_msr  = rd & (paddr == `UMS_OFS_MSR);
  wire        wr_fcr  = wr & (paddr == `UMS_OFS_FCR);
  wire        loop    = modem_control[`UMS_MCR_LOOP];
  wire        parity_on     = lcr[`UMS_LCR_PEN];
  wire [3:0]  nbits   = {2'b00, lcr[1:0]} + 4'd5;
  wire [AW:0] rcap    = fcr_en ? FULL : {{AW{1'b0}}, 1'b1};
  wire [AW:0] rlev    = ums_lvl(rx_trig, 1'b0);
  wire [AW:0] tlev    = ums_lvl(tx_trig, 1'b1);
  wire        prog_on = (PROG_TX_HOLD_EMPTY != 0) & int_enable_reg[`UMS_IER_PTIME] & fcr_en;
  wire        rx_rst  = wr_fcr & (pwdata[`UMS_FCR_RXRST] | (pwdata[0] != fcr_en));
  wire        tx_rst  = wr_fcr & (pwdata[`UMS_FCR_TXRST] | (pwdata[0] != fcr_en));
  wire        pop     = rd & (paddr == `UMS_OFS_DATA) & (rcount != 0);
  wire        tx_line = tx_sh[0];
  // Loop mode carries the break level and transmit data into the receiver
  wire        rx_in   = loop ? (tx_line & ~lcr[`UMS_LCR_BRK]) : sin;
  wire [7:0]  rx_data = rx_sh >> (4'd8 - nbits);
  wire        pe_calc = parity_on & (^rx_data ^ rx_p ^ ~lcr[`UMS_LCR_EPS]);
  wire [19:0] brk_thr = {16'h0000, 4'd2 + nbits + {3'b000, parity_on}} * {4'h0, DIV};
  wire [3:0]  msr_cur = loop ? {modem_control[3], modem_control[2], modem_control[0], modem_control[1]} : ~{dcd_n, ri_n, dsr_n, cts_n};
  wire [10:0] top     = rmem[rrp];
  wire        top_err = |top[10:8];
  wire        reveal  = (rcount != 0) & ~top_shown;
  wire        rx_full = (rcount == rcap) & ~pop;
  wire        tx_hold_empty_irq = prog_on ? (tcount <= tlev) : tx_hold_empty;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      int_enable_reg <= 8'h00;
      fcr_en <= 1'b0;
      rx_trig <= 2'h0;
      tx_trig <= 2'h0;
      lcr <= 7'h00;
      modem_control <= 6'h00;
    end else if (wr) begin
      case (paddr)
        `UMS_OFS_IER: int_enable_reg <= {pwdata[7], 3'b000, pwdata[3:0]};
        `UMS_OFS_FCR: begin
          fcr_en <= pwdata[0];
          rx_trig <= pwdata[7:6];
          if (PROG_TX_HOLD_EMPTY != 0) tx_trig <= pwdata[5:4];
        end
        `UMS_OFS_LCR: lcr <= pwdata[6:0];
        // Auto flow bit sticks at zero where the feature is not built
        `UMS_OFS_MCR: modem_control <= {pwdata[5] & (AUTO_FLOW_ENABLE_MODE != 0), pwdata[4:0]};
        default: ;
      endcase
    end
  end

  // Read data captured in setup phase; clears use the captured bits so nothing unseen is lost
  always @* begin
    next_prdata = 32'h00000000;
    case (paddr)
      `UMS_OFS_DATA: next_prdata[7:0] = top[7:0];
      `UMS_OFS_IER:  next_prdata[7:0] = int_enable_reg;
      `UMS_OFS_LCR:  next_prdata[6:0] = lcr;
      `UMS_OFS_MCR:  next_prdata[5:0] = modem_control;
      `UMS_OFS_LSR:  next_prdata[7:0] = {rx_fifo_error_summary, tx_all_empty, tx_hold_empty, lsr_bi, lsr_fe, lsr_pe, lsr_oe,
                                         rcount != 0};
      `UMS_OFS_MSR:  next_prdata[7:0] = {msr_cur[3], msr_cur[2], msr_cur[1], msr_cur[0], msr_delta};
      default: ;
    endcase
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) prdata <= 32'h00000000;
    else if (psel & ~penable & ~pwrite) prdata <= next_prdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) lo_cnt <= 20'h00000;
    else if (rx_in) lo_cnt <= 20'h00000;
    else if (lo_cnt != 20'hFFFFF) lo_cnt <= lo_cnt + 20'h00001;
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_st <= RX_IDLE;
      rx_cnt <= 16'h0000;
      rx_bit <= 3'h0;
      rx_sh <= 8'h00;
      rx_p <= 1'b0;
      rx_push <= 1'b0;
      rx_word <= 11'h000;
      brk_done <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      if (rx_cnt != 16'h0000) rx_cnt <= rx_cnt - 16'h0001;
      case (rx_st)
        RX_IDLE: if (!rx_in) begin
          rx_st <= RX_START;
          rx_cnt <= DIV >> 1;
        end
        RX_START: if (rx_cnt == 16'h0000) begin
          rx_st <= rx_in ? RX_IDLE : RX_DATA;
          rx_cnt <= DIV - 16'h0001;
          rx_bit <= 3'h0;
        end
        RX_DATA: if (rx_cnt == 16'h0000) begin
          rx_sh <= {rx_in, rx_sh[7:1]};
          rx_bit <= rx_bit + 3'h1;
          rx_cnt <= DIV - 16'h0001;
          if ({1'b0, rx_bit} == nbits - 4'd1) rx_st <= parity_on ? RX_PAR : RX_STOP;
        end
        RX_PAR: if (rx_cnt == 16'h0000) begin
          rx_p <= rx_in;
          rx_cnt <= DIV - 16'h0001;
          rx_st <= RX_STOP;
        end
        RX_STOP: if (rx_cnt == 16'h0000) begin
          rx_p <= 1'b0;
          if (rx_in) begin
            rx_push <= 1'b1;
            rx_word <= {2'b00, pe_calc, rx_data};
            rx_st <= RX_IDLE;
          end else if (rx_data == 8'h00 && !(parity_on && rx_p)) begin
            // Possible break: hold the character until the low time decides
            brk_done <= 1'b0;
            rx_st <= RX_BRK;
          end else begin
            rx_push <= 1'b1;
            rx_word <= {2'b01, pe_calc, rx_data};
            rx_cnt <= DIV - 16'h0001;
            rx_bit <= 3'h0;
            rx_st <= RX_DATA;
          end
        end
        RX_BRK: begin
          if (!brk_done && lo_cnt > brk_thr) begin
            rx_push <= 1'b1;
            rx_word <= 11'h700;
            brk_done <= 1'b1;
          end
          if (rx_in) begin
            if (!brk_done) begin
              rx_push <= 1'b1;
              rx_word <= {2'b01, pe_calc, 8'h00};
            end
            rx_st <= RX_IDLE;
          end
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive store; depth one without FIFOs
  always @(posedge sys_clk) begin
    if (rx_push && !rx_full) rmem[rwp] <= rx_word;
    else if (rx_push && !fcr_en) rmem[rrp] <= rx_word;
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rwp <= {AW{1'b0}};
      rrp <= {AW{1'b0}};
      rcount <= {(AW+1){1'b0}};
      err_cnt <= {(AW+1){1'b0}};
      top_shown <= 1'b0;
      rx_fifo_error_summary <= 1'b0;
      lsr_bi <= 1'b0;
      lsr_fe <= 1'b0;
      lsr_pe <= 1'b0;
      lsr_oe <= 1'b0;
    end else begin
      // Set wins over the read clear
      lsr_oe <= (lsr_oe & ~(rd_lsr & prdata[1])) | (rx_push & rx_full);
      // Clear and reveal in one term, so a read clears an old flag even as a new top shows
      lsr_bi <= (lsr_bi & ~(rd_lsr & prdata[4])) | (reveal & top[10]);
      lsr_fe <= (lsr_fe & ~(rd_lsr & prdata[3])) | (reveal & top[9]);
      lsr_pe <= (lsr_pe & ~(rd_lsr & prdata[2])) | (reveal & top[8]);
      if (reveal) top_shown <= 1'b1;
      if (rx_rst) begin
        rwp <= {AW{1'b0}};
        rrp <= {AW{1'b0}};
        rcount <= {(AW+1){1'b0}};
        err_cnt <= {(AW+1){1'b0}};
        top_shown <= 1'b0;
        rx_fifo_error_summary <= 1'b0;
      end else begin
        if (pop) begin
          rrp <= rrp + 1'b1;
          top_shown <= 1'b0;
        end
        if (rx_push && !rx_full) rwp <= rwp + 1'b1;
        else if (rx_push && !fcr_en) top_shown <= 1'b0;
        rcount <= rcount + {{AW{1'b0}}, rx_push & ~rx_full} - {{AW{1'b0}}, pop};
        err_cnt <= err_cnt + {{AW{1'b0}}, rx_push & (~rx_full | ~fcr_en) & (|rx_word[10:8])}
                   - {{AW{1'b0}}, (pop | (rx_push & rx_full & ~fcr_en)) & top_err};
        if (fcr_en && rx_push && !rx_full && (|rx_word[10:8])) rx_fifo_error_summary <= 1'b1;
        else if (rd_lsr && prdata[7] && top_err && err_cnt == 1) rx_fifo_error_summary <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit store and shifter
  wire        tx_load = ~tx_busy & (tcount != 0);
  wire [7:0]  t_dat   = tmem[trp] & ~(8'hFF << nbits);
  wire        t_par   = ~parity_on | (^t_dat ^ ~lcr[`UMS_LCR_EPS]);
  wire [11:0] t_frame = ({3'b000, t_dat, 1'b0} | (12'hFFE << nbits)) & ~({11'h000, ~t_par} << (nbits + 4'd1));
  wire [AW:0] tcap    = fcr_en ? FULL : {{AW{1'b0}}, 1'b1};
  wire        t_push  = wr & (paddr == `UMS_OFS_DATA) & (tcount != tcap);

  always @(posedge sys_clk) begin
    if (t_push) tmem[twp] <= pwdata[7:0];
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      twp <= {AW{1'b0}};
      trp <= {AW{1'b0}};
      tcount <= {(AW+1){1'b0}};
      tx_sh <= 12'hFFF;
      tx_cnt <= 16'h0000;
      tx_left <= 4'h0;
      tx_busy <= 1'b0;
      tx_hold_empty <= 1'b1;
      tx_all_empty <= 1'b1;
    end else begin
      if (tx_rst) begin
        twp <= {AW{1'b0}};
        trp <= {AW{1'b0}};
        tcount <= {(AW+1){1'b0}};
      end else begin
        if (t_push) twp <= twp + 1'b1;
        if (tx_load) trp <= trp + 1'b1;
        tcount <= tcount + {{AW{1'b0}}, t_push} - {{AW{1'b0}}, tx_load};
      end
      if (tx_load) begin
        tx_sh <= t_frame;
        tx_busy <= 1'b1;
        tx_cnt <= DIV - 16'h0001;
        // Start, data, parity, stop; a half stop bit is sent as a whole one
        tx_left <= nbits + {3'b000, parity_on} + {3'b000, lcr[`UMS_LCR_STOP]} + 4'd1;
      end else if (tx_busy) begin
        if (tx_cnt != 16'h0000) tx_cnt <= tx_cnt - 16'h0001;
        else begin
          tx_sh <= {1'b1, tx_sh[11:1]};
          tx_cnt <= DIV - 16'h0001;
          tx_left <= tx_left - 4'h1;
          if (tx_left == 4'h0) tx_busy <= 1'b0;
        end
      end
      // Holding-empty reports a full FIFO in threshold mode
      tx_hold_empty <= prog_on ? (tcount == FULL) : (tcount == 0);
      tx_all_empty <= (tcount == 0) & ~tx_busy & ~tx_load;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modem status and pins
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      msr_prev <= 4'h0;
      msr_delta <= 4'h0;
      sout <= 1'b1;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
      user_output_a_pin <= 1'b1;
      user_output_b_pin <= 1'b1;
      intr <= 1'b0;
    end else begin
      // Zero after reset lets asserted inputs other than ring flag a change
      msr_prev <= msr_cur;
      msr_delta <= (msr_delta & ~({4{rd_msr}} & prdata[3:0])) |
                   {msr_prev[3] ^ msr_cur[3], msr_prev[2] & ~msr_cur[2],
                    msr_prev[1] ^ msr_cur[1], msr_prev[0] ^ msr_cur[0]};
      sout <= loop | (tx_line & ~lcr[`UMS_LCR_BRK]);
      dtr_n <= loop | ~modem_control[0];
      user_output_a_pin <= loop | ~modem_control[2];
      user_output_b_pin <= loop | ~modem_control[3];
      rts_n <= loop | ~modem_control[1] | (modem_control[`UMS_MCR_AUTO_FLOW_ENABLE] & fcr_en & (rcount >= rlev));
      intr <= (int_enable_reg[0] & (fcr_en ? rcount >= rlev : rcount != 0)) |
              (int_enable_reg[1] & tx_hold_empty_irq) |
              (int_enable_reg[2] & (lsr_oe | lsr_pe | lsr_fe | lsr_bi)) |
              (int_enable_reg[3] & (|msr_delta));
    end
  end
endmodule // ums_uart

// ==== common/ums_uart_consts.vh ====
// Register offsets, field positions, reset values and timing defaults of the modem and line status block
`ifndef UMS_UART_CONSTS_VH
`define UMS_UART_CONSTS_VH
`define UMS_OFS_DATA 8'h00
`define UMS_OFS_IER 8'h04
`define UMS_OFS_FCR 8'h08
`define UMS_OFS_LCR 8'h0C
`define UMS_OFS_MCR 8'h10
`define UMS_OFS_LSR 8'h14
`define UMS_OFS_MSR 8'h18
`define UMS_MCR_LOOP 4
`define UMS_MCR_AUTO_FLOW_ENABLE 5
`define UMS_LCR_STOP 2
`define UMS_LCR_PEN 3
`define UMS_LCR_EPS 4
`define UMS_LCR_BRK 6
`define UMS_IER_PTIME 7
`define UMS_FCR_RXRST 1
`define UMS_FCR_TXRST 2
`define UMS_LSR_RST 8'h60
`define UMS_BAUD_DIV 16
`endif

// ==== verification/ums_uart_monitor.sv ====
// Concurrent checks on the modem control pins and the status reads of the UART
`include "ums_uart_consts.vh"
module ums_uart_monitor (
  input wire logic        sys_clk, nrst, psel, penable, pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic        sin, cts_n, dsr_n, dcd_n, ri_n, sout, rts_n, dtr_n,
  input wire logic        user_output_a_pin, user_output_b_pin, intr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] modem_control;
  logic [1:0] mage;
  logic [2:0] iage;
  logic [7:0] hi_cnt;
  logic [1:0] line_q;
  logic       fifo_on;
  logic       tx_used;
  wire        wr = psel && penable && pwrite;
  wire        settled = mage >= 2'h2;
  //////////////////////////////////////////////////////////////////////////////
  // Shadow of the control register; pins are judged only once a write has settled
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      {modem_control, mage, iage, hi_cnt, fifo_on, tx_used} <= '0;
      line_q <= 2'h3;
    end else begin
      if (wr && paddr == `UMS_OFS_MCR) modem_control <= pwdata[5:0];
      if (wr && paddr == `UMS_OFS_FCR) fifo_on <= pwdata[0];
      if (wr && paddr == `UMS_OFS_DATA) tx_used <= 1'b1;
      mage <= (wr && paddr == `UMS_OFS_MCR) ? 2'h0 : (mage == 2'h3 ? mage : mage + 2'h1);
      line_q <= {dcd_n, ri_n};
      // Status reads are captured in the setup cycle, so only long-stable levels are compared
      iage <= (line_q != {dcd_n, ri_n}) ? 3'h0 : (iage == 3'h7 ? iage : iage + 3'h1);
      hi_cnt <= !sin ? 8'h00 : (hi_cnt == 8'hFF ? hi_cnt : hi_cnt + 8'h01);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_read(logic [7:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  // Two status reads with an idle line between them; no error flag may be reported anew
  sequence s_lsr_pair;
    s_read(`UMS_OFS_LSR) ##3 (psel && penable && !pwrite && paddr == `UMS_OFS_LSR && !fifo_on && hi_cnt == 8'hFF);
  endsequence
  a_dtr_follow:
    assert property (settled |-> dtr_n == (modem_control[4] | ~modem_control[0])) else $error("terminal ready pin wrong");
  a_user_pins:
    assert property (settled |-> {user_output_b_pin, user_output_a_pin} == ({2{modem_control[4]}} | ~modem_control[3:2]))
      else $error("user output pins wrong");
  a_rts_manual:
    assert property (settled && !modem_control[5] |-> rts_n == (modem_control[4] | ~modem_control[1])) else $error("request pin wrong");
  a_rts_gate:
    assert property (settled && (modem_control[4] || !modem_control[1]) |-> rts_n) else $error("request pin asserted");
  a_sout_loop:
    assert property (settled && modem_control[4] |-> sout) else $error("serial out low in loop");
  a_msr_loop:
    assert property (s_read(`UMS_OFS_MSR) ##0 (modem_control[4] && settled) |-> prdata[7:6] == modem_control[3:2])
      else $error("looped carrier or ring bit wrong");
  a_msr_pins:
    assert property (s_read(`UMS_OFS_MSR) ##0 (!modem_control[4] && settled && iage == 3'h7) |-> prdata[7:6] == ~{dcd_n, ri_n})
      else $error("carrier or ring bit wrong");
  a_break_clear:
    assert property (s_lsr_pair |-> prdata[4:1] == 4'h0) else $error("error flags survive read");
  a_tx_all_empty_idle:
    assert property (s_read(`UMS_OFS_LSR) ##0 !tx_used |-> prdata[6:5] == 2'b11) else $error("empty flags low");
endmodule // ums_uart_monitor
bind ums_uart ums_uart_monitor mon_u (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .sin(sin), .cts_n(cts_n), .dsr_n(dsr_n),
  .dcd_n(dcd_n), .ri_n(ri_n), .sout(sout), .rts_n(rts_n), .dtr_n(dtr_n), .user_output_a_pin(user_output_a_pin),
  .user_output_b_pin(user_output_b_pin), .intr(intr));

// ==== verification/ums_modem_model.sv ====
// Behavioural modem that frames serial characters and drives the modem lines
module ums_modem_model #(parameter int DIV = 8) (
  input  wire logic sys_clk,
  output logic      sin, cts_n, dsr_n, dcd_n, ri_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle line is marking, all modem lines released
  initial {sin, cts_n, dsr_n, dcd_n, ri_n} = 5'h1F;
  task automatic bit_out(input logic b);
    sin = b;
    repeat (DIV) @(posedge sys_clk);
    #1;
  endtask
  // A zero stop bit makes a framing error on purpose
  task automatic send(input logic [7:0] d, input logic parity_on, input logic par, input logic stp);
    int i;
    bit_out(1'b0);
    for (i = 0; i < 8; i++) bit_out(d[i]);
    if (parity_on) bit_out(par);
    bit_out(stp);
    bit_out(1'b1);
  endtask
  task automatic brk(input int n);
    sin = 1'b0;
    repeat (n) @(posedge sys_clk);
    #1 sin = 1'b1;
  endtask
  task automatic lines(input logic [3:0] v);
    {cts_n, dsr_n, dcd_n, ri_n} = v;
  endtask
endmodule // ums_modem_model

// ==== verification/tb_ums_uart.sv ====
// Self-checking bench for the modem control and line status logic
`include "ums_uart_consts.vh"
module tb_ums_uart;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DIV = 8;
  logic        sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, rnd = 8'h62, d, e;
  logic [4:0]  m;
  logic [31:0] pwdata = 32'h0, prdata, q;
  wire         sin, cts_n, dsr_n, dcd_n, ri_n, sout, rts_n, dtr_n, ua, ub, intr;
  int          error_cnt = 0, checked = 0, i;
  always #5 sys_clk = ~sys_clk;
  ums_uart #(.BAUD_DIV(DIV)) dut_u (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .sin(sin), .cts_n(cts_n), .dsr_n(dsr_n),
    .dcd_n(dcd_n), .ri_n(ri_n), .sout(sout), .rts_n(rts_n), .dtr_n(dtr_n), .user_output_a_pin(ua),
    .user_output_b_pin(ub), .intr(intr));
  ums_modem_model #(.DIV(DIV)) modem_u (.sys_clk(sys_clk), .sin(sin), .cts_n(cts_n), .dsr_n(dsr_n),
    .dcd_n(dcd_n), .ri_n(ri_n));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // Idle edge first, so a strobe is never lowered and raised in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    #1 psel = 1'b1;
    pwrite = w;
    paddr = a;
    pwdata = wd;
    @(posedge sys_clk);
    #1 penable = 1'b1;
    @(posedge sys_clk);
    q = prdata;
    #1 psel = 1'b0;
    penable = 1'b0;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Whole run is near 1600 cycles; the limit leaves ample slack
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    results();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    #1 nrst = 1'b1;
    apb(1'b0, `UMS_OFS_LSR, 0);
    check(q, 32'h60);
    apb(1'b0, `UMS_OFS_MSR, 0);
    check(q & 32'hC0, 32'h0);
    for (i = 0; i < 10; i++) begin
      rnd = lfsr(rnd);
      m = (i == 8) ? 5'h1F : (i == 9) ? 5'h0F : rnd[4:0];
      modem_u.lines(rnd[7:4]);
      apb(1'b1, `UMS_OFS_MCR, {27'h0, m});
      repeat (3) @(posedge sys_clk);
      #1;
      check({27'h0, dtr_n, rts_n, ua, ub, sout},
            {27'h0, m[4] | ~m[0], m[4] | ~m[1], m[4] | ~m[2], m[4] | ~m[3], 1'b1});
      apb(1'b0, `UMS_OFS_MSR, 0);
      check(q & 32'hC0, {24'h0, m[4] ? m[3:2] : ~rnd[5:4], 6'h00});
    end
    apb(1'b1, `UMS_OFS_MCR, 0);
    $display("modem control done");
    apb(1'b1, `UMS_OFS_LCR, 32'h03);
    d = lfsr(rnd);
    e = lfsr(d);
    modem_u.send(d, 1'b0, 1'b0, 1'b1);
    apb(1'b0, `UMS_OFS_LSR, 0);
    check(q & 32'h01, 32'h01);
    apb(1'b0, `UMS_OFS_DATA, 0);
    check(q, {24'h0, d});
    modem_u.send(d, 1'b0, 1'b0, 1'b1);
    modem_u.send(e, 1'b0, 1'b0, 1'b1);
    apb(1'b0, `UMS_OFS_LSR, 0);
    check(q & 32'h03, 32'h03);
    apb(1'b0, `UMS_OFS_DATA, 0);
    check(q, {24'h0, e});
    apb(1'b0, `UMS_OFS_LSR, 0);
    check(q & 32'h03, 32'h00);
    $display("receive and overrun done");
    apb(1'b1, `UMS_OFS_LCR, 32'h0B);
    for (i = 0; i < 2; i++) begin
      rnd = lfsr(e);
      e = rnd;
      modem_u.send(rnd, 1'b1, ~^rnd ^ i[0], 1'b1);
      apb(1'b0, `UMS_OFS_LSR, 0);
      check(q & 32'h04, {29'h0, i[0], 2'b00});
      apb(1'b0, `UMS_OFS_DATA, 0);
    end
    apb(1'b1, `UMS_OFS_LCR, 32'h03);
    modem_u.send(d, 1'b0, 1'b0, 1'b0);
    apb(1'b0, `UMS_OFS_LSR, 0);
    check(q & 32'h0F, 32'h09);
    apb(1'b0, `UMS_OFS_DATA, 0);
    check(q, {24'h0, d});
    repeat (100) @(posedge sys_clk);
    apb(1'b0, `UMS_OFS_DATA, 0);
    check(q, 32'hFF);
    apb(1'b0, `UMS_OFS_LSR, 0);
    check(q & 32'h0F, 32'h00);
    $display("parity and framing done");
    modem_u.brk(20 * DIV);
    apb(1'b0, `UMS_OFS_LSR, 0);
    check(q, 32'h7D);
    apb(1'b0, `UMS_OFS_DATA, 0);
    check(q, 32'h00);
    repeat (300) @(posedge sys_clk);
    apb(1'b0, `UMS_OFS_LSR, 0);
    apb(1'b0, `UMS_OFS_LSR, 0);
    check(q & 32'h1F, 32'h00);
    $display("break done");
    apb(1'b1, `UMS_OFS_FCR, 32'h01);
    modem_u.send(e, 1'b0, 1'b0, 1'b0);
    repeat (100) @(posedge sys_clk);
    apb(1'b0, `UMS_OFS_LSR, 0);
    check(q, 32'hE9);
    apb(1'b0, `UMS_OFS_DATA, 0);
    check(q, {24'h0, e});
    apb(1'b0, `UMS_OFS_DATA, 0);
    check(q, 32'hFF);
    apb(1'b0, `UMS_OFS_LSR, 0);
    check(q & 32'h81, 32'h00);
    apb(1'b1, `UMS_OFS_DATA, {24'h0, d});
    apb(1'b0, `UMS_OFS_LSR, 0);
    check(q & 32'h40, 32'h00);
    repeat (14 * DIV) @(posedge sys_clk);
    apb(1'b0, `UMS_OFS_LSR, 0);
    check(q & 32'h60, 32'h60);
    apb(1'b1, `UMS_OFS_IER, 32'h02);
    @(posedge sys_clk);
    #1;
    check({31'h0, intr}, 32'h1);
    apb(1'b0, `UMS_OFS_MSR, 0);
    apb(1'b1, `UMS_OFS_IER, 32'h08);
    @(posedge sys_clk);
    #1;
    check({31'h0, intr}, 32'h0);
    modem_u.lines(~{cts_n, dsr_n, dcd_n, ri_n});
    repeat (2) @(posedge sys_clk);
    #1;
    check({31'h0, intr}, 32'h1);
    $display("fifo and transmit done");
    results();
  end
endmodule // tb_ums_uart
